// ---- pmcl_map.vh ----
/*
 * Register offsets, field positions, reset values and bus-variant codes
 * for the port mode configuration logic.
 * Assumes an 8-bit host address within the io_register_space window.
 */
`ifndef PMCL_MAP_VH
`define PMCL_MAP_VH

`define PMCL_AW               8
`define PMCL_DW               8
`define PMCL_OFF_DOUT_A       8'h00
`define PMCL_OFF_DOUT_B       8'h01
`define PMCL_OFF_DOUT_C       8'h02
`define PMCL_OFF_DOUT_D       8'h03
`define PMCL_OFF_MODE_A       8'h04
`define PMCL_OFF_MODE_B       8'h05
`define PMCL_OFF_DIR_A        8'h06
`define PMCL_OFF_DIR_B        8'h07
`define PMCL_OFF_DIR_C        8'h08
`define PMCL_OFF_DIR_D        8'h09
`define PMCL_OFF_DRV_A        8'h0A
`define PMCL_OFF_DRV_B        8'h0B
`define PMCL_OFF_DRV_C        8'h0C
`define PMCL_OFF_DRV_D        8'h0D
`define PMCL_OFF_MEM_MODE     8'h0E
`define PMCL_OFF_EN_OUT_A     8'h10
`define PMCL_OFF_EN_OUT_B     8'h11
`define PMCL_OFF_EN_OUT_C     8'h12
`define PMCL_OFF_EN_OUT_D     8'h13
`define PMCL_OFF_ADDR_IN_A    8'h14
`define PMCL_OFF_ADDR_IN_B    8'h15
`define PMCL_OFF_ADDR_IN_C    8'h16
`define PMCL_OFF_ADDR_IN_D    8'h17

`define PMCL_RST_VAL          8'h00
`define PMCL_PORT_D_MASK      8'h07
`define PMCL_MEM_MODE_PERIPH  7

`define PMCL_BUS_MUX8         2'h0
`define PMCL_BUS_ALT_A        2'h1
`define PMCL_BUS_ALT_PAGE     2'h2
`define PMCL_BUS_NONMUX8      2'h3

`endif

// ---- pmcl_pin_sync.v ----
/*
 * Three-stage pin synchroniser with agreement filter.
 * Assumes asynchronous pin levels and one system clock.
 */
`timescale 1ns/1ps
module pmcl_pin_sync #(
    parameter W = 8
) (
    input  wire         clk_sys,
    input  wire         rst,
    input  wire [W-1:0] pin_async,
    output reg  [W-1:0] pin_sync_q
);
    reg [W-1:0] s1_q;
    reg [W-1:0] s2_q;
    reg [W-1:0] s3_q;
    integer     i;

    // A new level is accepted only once stages two and three agree
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            s1_q       <= {W{1'b0}};
            s2_q       <= {W{1'b0}};
            s3_q       <= {W{1'b0}};
            pin_sync_q <= {W{1'b0}};
        end else begin
            s1_q <= pin_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
            for (i = 0; i < W; i = i + 1) begin
                if (s2_q[i] == s3_q[i]) begin
                    pin_sync_q[i] <= s3_q[i];
                end
            end
        end
    end
endmodule

// ---- pmcl_top.v ----
/*
 * Mode, direction and drive configuration for ports A, B, C (8 pins) and
 * D (3 pins): host I/O, logic I/O, address out/in, data port, peripheral
 * buffer and JTAG sharing, with the host register file.
 * Assumes a synchronous host strobe interface on clk_sys, product terms
 * and address latch from same-clock logic, and pins resolved outside.
 */
`timescale 1ns/1ps
`include "pmcl_map.vh"
module pmcl_top #(
    parameter JTAG_TDO_PIN = 3
) (
    input  wire        clk_sys,
    input  wire        rst,
    input  wire [7:0]  host_addr,
    input  wire        host_wr,
    input  wire        host_rd,
    input  wire [7:0]  host_wdata,
    output reg  [7:0]  host_rdata_q,
    input  wire [1:0]  bus_variant,
    input  wire        data_port_en,
    input  wire        data_port_drive,
    input  wire [7:0]  data_port_wdata,
    output wire [7:0]  data_port_rdata,
    input  wire        peripheral_select_a,
    input  wire        peripheral_select_b,
    input  wire        periph_write,
    output wire [7:0]  periph_rdata,
    input  wire [15:0] addr_latched,
    input  wire        addr_strobe,
    input  wire [7:0]  pt_oe_a,
    input  wire [7:0]  pt_oe_b,
    input  wire [7:0]  pt_oe_c,
    input  wire [2:0]  pt_oe_d,
    input  wire [7:0]  pld_use_a,
    input  wire [7:0]  pld_use_b,
    input  wire [7:0]  pld_use_c,
    input  wire [2:0]  pld_use_d,
    input  wire [7:0]  pld_out_a,
    input  wire [7:0]  pld_out_b,
    input  wire [7:0]  pld_out_c,
    input  wire [2:0]  pld_out_d,
    input  wire        jtag_en,
    input  wire        jtag_tdo,
    input  wire        jtag_tdo_en,
    input  wire [7:0]  pa_in,
    input  wire [7:0]  pb_in,
    input  wire [7:0]  pc_in,
    input  wire [2:0]  pd_in,
    output wire [7:0]  pin_sync_a,
    output wire [7:0]  pin_sync_b,
    output wire [7:0]  pin_sync_c,
    output wire [2:0]  pin_sync_d,
    output reg  [7:0]  pa_out_q,
    output reg  [7:0]  pa_oe_n_q,
    output reg  [7:0]  pb_out_q,
    output reg  [7:0]  pb_oe_n_q,
    output reg  [7:0]  pc_out_q,
    output reg  [7:0]  pc_oe_n_q,
    output reg  [2:0]  pd_out_q,
    output reg  [2:0]  pd_oe_n_q,
    output wire [3:0]  pa_slew_fast,
    output wire [3:0]  pb_slew_fast,
    output wire [2:0]  pd_slew_fast,
    output reg  [7:0]  addr_in_a_q,
    output reg  [7:0]  addr_in_b_q,
    output reg  [7:0]  addr_in_c_q,
    output reg  [2:0]  addr_in_d_q
);
    reg  [7:0] dout_a_q, dout_b_q, dout_c_q;
    reg  [2:0] dout_d_q;
    reg  [7:0] port_mode_select_a_q, port_mode_select_b_q;
    reg  [7:0] pin_direction_a_q, pin_direction_b_q, pin_direction_c_q;
    reg  [2:0] pin_direction_d_q;
    reg  [7:0] pin_drive_select_a_q, pin_drive_select_b_q;
    reg  [7:0] pin_drive_select_c_q;
    reg  [2:0] pin_drive_select_d_q;
    reg  [7:0] memory_mode_register_q;
    reg  [7:0] pa_val_d, pa_en_d, pb_val_d, pb_en_d, pc_val_d, pc_en_d;
    reg  [2:0] pd_val_d, pd_en_d;
    reg  [7:0] rdata_d;
    reg  [4:0] nib;
    wire       periph_mode;
    wire       psel_any;
    wire [7:0] pa_od_mask;
    integer    i;
    // Returns {valid, nibble}; port_b picks B, hi picks pins 7..4
    function [4:0] addr_nibble;
        input       port_b;
        input       hi;
        input [1:0] variant;
        input [15:0] adr;
        begin
            addr_nibble = 5'h00;
            case (variant)
                `PMCL_BUS_MUX8: begin
                    addr_nibble = {1'b1, hi ? adr[7:4] : adr[3:0]};
                end
                `PMCL_BUS_ALT_A: begin
                    if (!port_b && hi) begin
                        addr_nibble = {1'b1, adr[7:4]};
                    end else if (port_b && !hi) begin
                        addr_nibble = {1'b1, adr[11:8]};
                    end
                end
                `PMCL_BUS_ALT_PAGE: begin
                    if (port_b) begin
                        addr_nibble = {1'b1, hi ? adr[15:12] : adr[11:8]};
                    end
                end
                `PMCL_BUS_NONMUX8: begin
                    if (port_b) begin
                        addr_nibble = {1'b1, hi ? adr[7:4] : adr[3:0]};
                    end
                end
                default: addr_nibble = 5'h00;
            endcase
        end
    endfunction
    pmcl_pin_sync #(.W(8)) u_sync_a (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .pin_async  (pa_in),
        .pin_sync_q (pin_sync_a)
    );
    pmcl_pin_sync #(.W(8)) u_sync_b (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .pin_async  (pb_in),
        .pin_sync_q (pin_sync_b)
    );
    pmcl_pin_sync #(.W(8)) u_sync_c (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .pin_async  (pc_in),
        .pin_sync_q (pin_sync_c)
    );
    pmcl_pin_sync #(.W(3)) u_sync_d (
        .clk_sys    (clk_sys),
        .rst        (rst),
        .pin_async  (pd_in),
        .pin_sync_q (pin_sync_d)
    );
    assign periph_mode = memory_mode_register_q[`PMCL_MEM_MODE_PERIPH];
    assign psel_any    = peripheral_select_a | peripheral_select_b;
    assign data_port_rdata = pin_sync_a;
    assign periph_rdata    = pin_sync_a;
    // Low nibble of A/B drive-select is slew, D uses its three bits
    assign pa_slew_fast = pin_drive_select_a_q[3:0];
    assign pb_slew_fast = pin_drive_select_b_q[3:0];
    assign pd_slew_fast = pin_drive_select_d_q;
    // Takeover modes drive both levels; open drain also applies to general I/O and address-out pins
    assign pa_od_mask = (data_port_en | periph_mode) ? 8'h00
                      : {pin_drive_select_a_q[7:4], 4'h0};
    // Host register writes; each register is a plain store
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            dout_a_q               <= `PMCL_RST_VAL;
            dout_b_q               <= `PMCL_RST_VAL;
            dout_c_q               <= `PMCL_RST_VAL;
            dout_d_q               <= 3'h0;
            port_mode_select_a_q   <= `PMCL_RST_VAL;
            port_mode_select_b_q   <= `PMCL_RST_VAL;
            pin_direction_a_q      <= `PMCL_RST_VAL;
            pin_direction_b_q      <= `PMCL_RST_VAL;
            pin_direction_c_q      <= `PMCL_RST_VAL;
            pin_direction_d_q      <= 3'h0;
            pin_drive_select_a_q   <= `PMCL_RST_VAL;
            pin_drive_select_b_q   <= `PMCL_RST_VAL;
            pin_drive_select_c_q   <= `PMCL_RST_VAL;
            pin_drive_select_d_q   <= 3'h0;
            memory_mode_register_q <= `PMCL_RST_VAL;
        end else if (host_wr) begin
            case (host_addr)
                `PMCL_OFF_DOUT_A:   dout_a_q <= host_wdata;
                `PMCL_OFF_DOUT_B:   dout_b_q <= host_wdata;
                `PMCL_OFF_DOUT_C:   dout_c_q <= host_wdata;
                `PMCL_OFF_DOUT_D:   dout_d_q <= host_wdata[2:0];
                `PMCL_OFF_MODE_A:   port_mode_select_a_q <= host_wdata;
                `PMCL_OFF_MODE_B:   port_mode_select_b_q <= host_wdata;
                `PMCL_OFF_DIR_A:    pin_direction_a_q <= host_wdata;
                `PMCL_OFF_DIR_B:    pin_direction_b_q <= host_wdata;
                `PMCL_OFF_DIR_C:    pin_direction_c_q <= host_wdata;
                `PMCL_OFF_DIR_D:    pin_direction_d_q <= host_wdata[2:0];
                `PMCL_OFF_DRV_A:    pin_drive_select_a_q <= host_wdata;
                `PMCL_OFF_DRV_B:    pin_drive_select_b_q <= host_wdata;
                `PMCL_OFF_DRV_C:    pin_drive_select_c_q <= host_wdata;
                `PMCL_OFF_DRV_D:    pin_drive_select_d_q <= host_wdata[2:0];
                `PMCL_OFF_MEM_MODE: memory_mode_register_q <= host_wdata;
                default: ;
            endcase
        end
    end
    // Read data; unmapped offsets and unimplemented D bits read zero
    always @* begin
        case (host_addr)
            `PMCL_OFF_DOUT_A:    rdata_d = dout_a_q;
            `PMCL_OFF_DOUT_B:    rdata_d = dout_b_q;
            `PMCL_OFF_DOUT_C:    rdata_d = dout_c_q;
            `PMCL_OFF_DOUT_D:    rdata_d = {5'h00, dout_d_q};
            `PMCL_OFF_MODE_A:    rdata_d = port_mode_select_a_q;
            `PMCL_OFF_MODE_B:    rdata_d = port_mode_select_b_q;
            `PMCL_OFF_DIR_A:     rdata_d = pin_direction_a_q;
            `PMCL_OFF_DIR_B:     rdata_d = pin_direction_b_q;
            `PMCL_OFF_DIR_C:     rdata_d = pin_direction_c_q;
            `PMCL_OFF_DIR_D:     rdata_d = {5'h00, pin_direction_d_q};
            `PMCL_OFF_DRV_A:     rdata_d = pin_drive_select_a_q;
            `PMCL_OFF_DRV_B:     rdata_d = pin_drive_select_b_q;
            `PMCL_OFF_DRV_C:     rdata_d = pin_drive_select_c_q;
            `PMCL_OFF_DRV_D:     rdata_d = {5'h00, pin_drive_select_d_q};
            `PMCL_OFF_MEM_MODE:  rdata_d = memory_mode_register_q;
            `PMCL_OFF_EN_OUT_A:  rdata_d = ~pa_oe_n_q;
            `PMCL_OFF_EN_OUT_B:  rdata_d = ~pb_oe_n_q;
            `PMCL_OFF_EN_OUT_C:  rdata_d = ~pc_oe_n_q;
            `PMCL_OFF_EN_OUT_D:  rdata_d = {5'h00, ~pd_oe_n_q};
            `PMCL_OFF_ADDR_IN_A: rdata_d = addr_in_a_q;
            `PMCL_OFF_ADDR_IN_B: rdata_d = addr_in_b_q;
            `PMCL_OFF_ADDR_IN_C: rdata_d = addr_in_c_q;
            `PMCL_OFF_ADDR_IN_D: rdata_d = {5'h00, addr_in_d_q};
            default:             rdata_d = 8'h00;
        endcase
    end

    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            host_rdata_q <= 8'h00;
        end else if (host_rd) begin
            host_rdata_q <= rdata_d;
        end
    end
    // Address inputs on every port are caught on the strobe
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            addr_in_a_q <= 8'h00;
            addr_in_b_q <= 8'h00;
            addr_in_c_q <= 8'h00;
            addr_in_d_q <= 3'h0;
        end else if (addr_strobe) begin
            addr_in_a_q <= pin_sync_a;
            addr_in_b_q <= pin_sync_b;
            addr_in_c_q <= pin_sync_c;
            addr_in_d_q <= pin_sync_d;
        end
    end
    // Per-pin source and enable; bit i looks at bit i except on address-out pins, which take nibble bits
    always @* begin
        nib = 5'h00;
        for (i = 0; i < 8; i = i + 1) begin
            // Port A
            pa_en_d[i] = pin_direction_a_q[i] | pt_oe_a[i];
            pa_val_d[i] = pld_use_a[i] ? pld_out_a[i] : dout_a_q[i];
            if (port_mode_select_a_q[i]) begin
                nib = addr_nibble(1'b0, i >= 4, bus_variant, addr_latched);
                pa_val_d[i] = nib[i % 4];
                pa_en_d[i] = nib[4] &
                    (pt_oe_a[i] | pin_direction_a_q[i]);
            end
            // Port B
            pb_en_d[i] = pin_direction_b_q[i] | pt_oe_b[i];
            pb_val_d[i] = pld_use_b[i] ? pld_out_b[i] : dout_b_q[i];
            if (port_mode_select_b_q[i]) begin
                nib = addr_nibble(1'b1, i >= 4, bus_variant, addr_latched);
                pb_val_d[i] = nib[i % 4];
                pb_en_d[i] = nib[4] &
                    (pt_oe_b[i] | pin_direction_b_q[i]);
            end
            // Port C; JTAG owns its output pin while enabled
            pc_en_d[i] = pin_direction_c_q[i] | pt_oe_c[i];
            pc_val_d[i] = pld_use_c[i] ? pld_out_c[i] : dout_c_q[i];
            if (jtag_en && i == JTAG_TDO_PIN) begin
                pc_en_d[i] = jtag_tdo_en;
                pc_val_d[i] = jtag_tdo;
            end
        end
        // Port A takeover; data port beats peripheral buffer
        if (data_port_en) begin
            pa_en_d  = {8{data_port_drive}};
            pa_val_d = data_port_wdata;
        end else if (periph_mode) begin
            pa_en_d  = {8{psel_any & periph_write}};
            pa_val_d = host_wdata;
        end
        for (i = 0; i < 3; i = i + 1) begin
            pd_en_d[i]  = pin_direction_d_q[i] | pt_oe_d[i];
            pd_val_d[i] = pld_use_d[i] ? pld_out_d[i] : dout_d_q[i];
        end
    end
    // Open-drain bits release the pin rather than drive a one
    always @(posedge clk_sys or posedge rst) begin
        if (rst) begin
            pa_out_q  <= 8'h00;
            pa_oe_n_q <= 8'hFF;
            pb_out_q  <= 8'h00;
            pb_oe_n_q <= 8'hFF;
            pc_out_q  <= 8'h00;
            pc_oe_n_q <= 8'hFF;
            pd_out_q  <= 3'h0;
            pd_oe_n_q <= 3'h7;
        end else begin
            pa_out_q  <= pa_val_d;
            pa_oe_n_q <= ~(pa_en_d & ~(pa_od_mask & pa_val_d));
            pb_out_q  <= pb_val_d;
            pb_oe_n_q <= ~(pb_en_d & ~({pin_drive_select_b_q[7:4], 4'h0}
                         & pb_val_d));
            pc_out_q  <= pc_val_d;
            pc_oe_n_q <= ~(pc_en_d
                         & ~(pin_drive_select_c_q & pc_val_d));
            pd_out_q  <= pd_val_d;
            pd_oe_n_q <= ~pd_en_d;
        end
    end
endmodule

// ---- pmcl_host_model.sv ----
/*
 * Host microcontroller model: byte register writes and reads.
 * Assumes the single clk_sys domain and one-cycle host strobes.
 */
`timescale 1ns/1ps
module pmcl_host_model (
    input  wire [0:0] clk_sys,
    input  wire [7:0] host_rdata_q,
    output reg  [7:0] host_addr = 8'h00,
    output reg        host_wr = 1'b0,
    output reg        host_rd = 1'b0,
    output reg  [7:0] host_wdata = 8'h00
);
    // Setup happens at run time; direction is never set on logic inputs
    task wr(input [7:0] a, input [7:0] d);
        @(posedge clk_sys);
        host_addr <= a;
        host_wdata <= d;
        host_wr <= 1'b1;
        @(posedge clk_sys);
        host_wr <= 1'b0;
        // A released bus must not keep showing the last byte
        host_wdata <= ~d;
    endtask
    task rd(input [7:0] a, output [7:0] d);
        @(posedge clk_sys);
        host_addr <= a;
        host_rd <= 1'b1;
        @(posedge clk_sys);
        host_rd <= 1'b0;
        #1 d = host_rdata_q;
    endtask
endmodule

// ---- pmcl_asserts.sv ----
/*
 * Concurrent checks on the pins of the port configuration top level.
 * Assumes one clk_sys domain and the offsets of the register map header.
 */
`timescale 1ns/1ps
`include "pmcl_map.vh"
module pmcl_asserts #(
    parameter JTAG_TDO_PIN = 3
) (
    input logic       clk_sys,
    input logic       rst,
    input logic [7:0] host_addr,
    input logic       host_wr,
    input logic       host_rd,
    input logic [7:0] host_wdata,
    input logic [7:0] host_rdata_q,
    input logic       data_port_en,
    input logic       data_port_drive,
    input logic [7:0] data_port_wdata,
    input logic [2:0] pin_sync_d,
    input logic       addr_strobe,
    input logic [2:0] addr_in_d_q,
    input logic [2:0] pt_oe_d,
    input logic [2:0] pd_oe_n_q,
    input logic [2:0] pd_slew_fast,
    input logic [7:0] pa_out_q,
    input logic [7:0] pa_oe_n_q,
    input logic       jtag_en,
    input logic       jtag_tdo_en,
    input logic [7:0] pc_oe_n_q
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (rst);
    property p_rd_hold; !host_rd |=> $stable(host_rdata_q); endproperty
    a_rd_hold: assert property (p_rd_hold)
        else $error("read data moved without a read");
    property p_pt_d; pt_oe_d != 3'h0 |=> (pd_oe_n_q & $past(pt_oe_d)) == 3'h0;
    endproperty
    a_pt_d: assert property (p_pt_d)
        else $error("enable term did not drive port D");
    property p_dir_d;
        host_wr && host_addr == `PMCL_OFF_DIR_D ##1 (!host_wr && pt_oe_d == 3'h0)
        |=> pd_oe_n_q == ~$past(host_wdata[2:0], 2);
    endproperty
    a_dir_d: assert property (p_dir_d)
        else $error("port D drive does not follow direction");
    property p_slew_d;
        host_wr && host_addr == `PMCL_OFF_DRV_D ##1 !host_wr
        |=> pd_slew_fast == $past(host_wdata[2:0], 2);
    endproperty
    a_slew_d: assert property (p_slew_d)
        else $error("port D slew does not follow drive bits");
    property p_addr_in; addr_strobe |=> addr_in_d_q == $past(pin_sync_d);
    endproperty
    a_addr_in: assert property (p_addr_in)
        else $error("address input not captured on strobe");
    property p_dp_drive; data_port_en && data_port_drive
        |=> pa_oe_n_q == 8'h00 && pa_out_q == $past(data_port_wdata);
    endproperty
    a_dp_drive: assert property (p_dp_drive)
        else $error("data port not driven on port A");
    property p_dp_off; data_port_en && !data_port_drive |=> pa_oe_n_q == 8'hFF;
    endproperty
    a_dp_off: assert property (p_dp_off)
        else $error("port A driven while data port reads");
    property p_jtag; jtag_en && !jtag_tdo_en |=> pc_oe_n_q[JTAG_TDO_PIN];
    endproperty
    a_jtag: assert property (p_jtag)
        else $error("scan output pin driven without enable");
    c_dp: cover property (data_port_en && data_port_drive);
    c_strobe: cover property (addr_strobe);
    c_jtag: cover property (jtag_en && jtag_tdo_en);
endmodule

bind pmcl_top pmcl_asserts #(.JTAG_TDO_PIN(JTAG_TDO_PIN)) u_chk (
    .clk_sys(clk_sys), .rst(rst), .host_addr(host_addr), .host_wr(host_wr),
    .host_rd(host_rd), .host_wdata(host_wdata), .host_rdata_q(host_rdata_q),
    .data_port_en(data_port_en), .data_port_drive(data_port_drive),
    .data_port_wdata(data_port_wdata), .pin_sync_d(pin_sync_d),
    .addr_strobe(addr_strobe), .addr_in_d_q(addr_in_d_q), .pt_oe_d(pt_oe_d),
    .pd_oe_n_q(pd_oe_n_q), .pd_slew_fast(pd_slew_fast), .pa_out_q(pa_out_q),
    .pa_oe_n_q(pa_oe_n_q), .jtag_en(jtag_en), .jtag_tdo_en(jtag_tdo_en),
    .pc_oe_n_q(pc_oe_n_q));

// ---- pmcl_tb.sv ----
/*
 * Self-checking bench for pmcl_top with a host model and a register model.
 * Assumes the offsets and masks of the register map header.
 */
`timescale 1ns/1ps
`include "pmcl_map.vh"
`define CHK(a, e) begin checks_done++; if ((a) !== (e)) begin num_errors++; \
 $display("FAIL %0t got %h exp %h", $time, a, e); end end
module tb;
    reg         clk_sys = 1'b0, rst = 1'b1;
    wire [7:0]  host_addr, host_wdata, host_rdata_q, data_port_rdata;
    wire        host_wr, host_rd;
    reg  [1:0]  bus_variant = 2'h0;
    reg         data_port_en = 1'b0, data_port_drive = 1'b0, addr_strobe = 1'b0;
    reg         peripheral_select_a = 1'b0, peripheral_select_b = 1'b0;
    reg         periph_write = 1'b0, jtag_en = 1'b0, jtag_tdo = 1'b0;
    reg         jtag_tdo_en = 1'b0;
    reg  [7:0]  data_port_wdata = 8'h00, pa_in = 8'h00, pb_in = 8'h00;
    reg  [7:0]  pc_in = 8'h00, pt_oe_a = 8'h00, pt_oe_b = 8'h00;
    reg  [7:0]  pt_oe_c = 8'h00, pld_use_a = 8'h00, pld_use_b = 8'h00;
    reg  [7:0]  pld_use_c = 8'h00, pld_out_a = 8'h00, pld_out_b = 8'h00;
    reg  [7:0]  pld_out_c = 8'h00;
    reg  [2:0]  pt_oe_d = 3'h0, pld_use_d = 3'h0, pld_out_d = 3'h0, pd_in = 3'h0;
    reg  [15:0] addr_latched = 16'h0000;
    wire [7:0]  pa_out_q, pa_oe_n_q, pb_out_q, pb_oe_n_q, pc_out_q, pc_oe_n_q;
    wire [7:0]  addr_in_a_q, addr_in_b_q, addr_in_c_q, periph_rdata;
    wire [7:0]  pin_sync_a, pin_sync_b, pin_sync_c;
    wire [2:0]  pd_out_q, pd_oe_n_q, pin_sync_d;
    wire [3:0]  pa_slew_fast, pb_slew_fast;
    int         num_errors = 0, checks_done = 0;
    int         regm [256];
    int         sel [4][4] = '{'{0,1,0,1}, '{4,1,2,4}, '{4,4,2,3}, '{4,4,0,1}};

    always #25 clk_sys = ~clk_sys;

    pmcl_host_model u_host (.clk_sys(clk_sys), .host_rdata_q(host_rdata_q),
        .host_addr(host_addr), .host_wr(host_wr), .host_rd(host_rd),
        .host_wdata(host_wdata));
    pmcl_top dut (.clk_sys(clk_sys), .rst(rst), .host_addr(host_addr),
        .host_wr(host_wr), .host_rd(host_rd), .host_wdata(host_wdata),
        .host_rdata_q(host_rdata_q), .bus_variant(bus_variant),
        .data_port_en(data_port_en), .data_port_drive(data_port_drive),
        .data_port_wdata(data_port_wdata), .data_port_rdata(data_port_rdata),
        .peripheral_select_a(peripheral_select_a),
        .periph_rdata(periph_rdata),
        .peripheral_select_b(peripheral_select_b), .periph_write(periph_write),
        .addr_latched(addr_latched), .addr_strobe(addr_strobe),
        .pt_oe_a(pt_oe_a), .pt_oe_b(pt_oe_b), .pt_oe_c(pt_oe_c),
        .pt_oe_d(pt_oe_d), .pld_use_a(pld_use_a), .pld_use_b(pld_use_b),
        .pld_use_c(pld_use_c), .pld_use_d(pld_use_d), .pld_out_a(pld_out_a),
        .pld_out_b(pld_out_b), .pld_out_c(pld_out_c), .pld_out_d(pld_out_d),
        .jtag_en(jtag_en), .jtag_tdo(jtag_tdo), .jtag_tdo_en(jtag_tdo_en),
        .pa_in(pa_in), .pb_in(pb_in), .pc_in(pc_in), .pd_in(pd_in),
        .pin_sync_a(pin_sync_a), .pin_sync_b(pin_sync_b),
        .pin_sync_c(pin_sync_c), .pin_sync_d(pin_sync_d),
        .pa_out_q(pa_out_q), .pa_oe_n_q(pa_oe_n_q), .pb_out_q(pb_out_q),
        .pb_oe_n_q(pb_oe_n_q), .pc_out_q(pc_out_q), .pc_oe_n_q(pc_oe_n_q),
        .pd_out_q(pd_out_q), .pd_oe_n_q(pd_oe_n_q), .pa_slew_fast(pa_slew_fast),
        .pb_slew_fast(pb_slew_fast), .pd_slew_fast(), .addr_in_a_q(addr_in_a_q),
        .addr_in_b_q(addr_in_b_q), .addr_in_c_q(addr_in_c_q),
        .addr_in_d_q());

    task w(input int n);
        repeat (n) @(posedge clk_sys);
        #1;
    endtask
    function automatic [7:0] msk(input [7:0] a);
        msk = (a == `PMCL_OFF_DOUT_D || a == `PMCL_OFF_DIR_D ||
               a == `PMCL_OFF_DRV_D) ? 8'h07 : 8'hFF;
    endfunction
    task wr(input [7:0] a, input [7:0] d);
        u_host.wr(a, d);
        regm[a] = d & msk(a);
    endtask
    task rdc(input [7:0] a, input [7:0] e);
        reg [7:0] d;
        u_host.rd(a, d);
        `CHK(d, e)
    endtask
    task end_sim;
        $display("checks %0d mismatches %0d", checks_done, num_errors);
        if (num_errors == 0 && checks_done > 0)
            $display("Finished cleanly");
        else
            $display("Finished with errors");
        $finish;
    endtask

    initial begin
        #(20000 * 50);
        num_errors++;
        end_sim;
    end

    initial begin
        int k, v, s;
        reg [7:0] e, d;
        reg [15:0] eo, ev;
        void'($urandom(56));
        foreach (regm[i]) regm[i] = 0;
        w(3);
        `CHK({pa_oe_n_q, pd_oe_n_q, host_rdata_q}, 19'h7FF00)
        repeat (2) @(posedge clk_sys);
        rst <= 1'b0;
        for (k = 0; k < 15; k++) rdc(k[7:0], 8'h00);
        for (k = 0; k < 14; k++) wr(k[7:0], 8'($urandom));
        for (k = 0; k < 14; k++) rdc(k[7:0], regm[k][7:0]);
        wr(8'h20, 8'hFF);
        rdc(8'h20, 8'h00);
        $display("test registers done");
        for (k = 0; k < 8; k++) begin
            wr(`PMCL_OFF_DIR_D, 8'($urandom));
            wr(`PMCL_OFF_DOUT_D, 8'($urandom));
            @(posedge clk_sys);
            {pt_oe_d, pld_use_d, pld_out_d, pd_in} <= 12'($urandom);
            {pt_oe_a, pt_oe_b, pt_oe_c, pa_in} <= $urandom;
            {pld_use_a, pld_use_b, pld_use_c, pb_in} <= $urandom;
            {pld_out_a, pld_out_b, pld_out_c, pc_in} <= $urandom;
            w(2);
            e = {5'h00, regm[9][2:0] | pt_oe_d};
            d = {5'h00, (pld_use_d & pld_out_d) | (~pld_use_d & regm[3][2:0])};
            `CHK(pd_oe_n_q, ~e[2:0])
            `CHK(pd_out_q & e[2:0], d[2:0] & e[2:0])
            rdc(`PMCL_OFF_EN_OUT_D, e);
        end
        @(posedge clk_sys);
        {pt_oe_a, pt_oe_b, pt_oe_c, pld_use_a, pld_use_b, pld_use_c} <= 48'h0;
        {pt_oe_d, pld_use_d} <= 6'h00;
        $display("test port D done");
        for (k = 4; k < 8; k++) wr(k[7:0], 8'hFF);
        wr(`PMCL_OFF_DRV_A, 8'h00);
        wr(`PMCL_OFF_DRV_B, 8'h00);
        for (v = 0; v < 4; v++) begin
            @(posedge clk_sys);
            bus_variant <= v[1:0];
            addr_latched <= 16'($urandom);
            w(3);
            for (k = 0; k < 4; k++) begin
                s = sel[v][k];
                eo[4*k +: 4] = (s == 4) ? 4'hF : 4'h0;
                ev[4*k +: 4] = addr_latched[4*(s%4) +: 4];
            end
            `CHK({pb_oe_n_q, pa_oe_n_q}, eo)
            `CHK({pb_out_q, pa_out_q} & ~eo, ev & ~eo)
        end
        wr(`PMCL_OFF_DIR_B, 8'h00);
        w(2);
        `CHK(pb_oe_n_q, 8'hFF)
        $display("test address out done");
        wr(`PMCL_OFF_DRV_A, 8'hFF);
        wr(`PMCL_OFF_DRV_B, 8'hA5);
        wr(`PMCL_OFF_DRV_C, 8'hFF);
        wr(`PMCL_OFF_DIR_C, 8'hFF);
        wr(`PMCL_OFF_DOUT_C, 8'h55);
        w(2);
        `CHK({pa_slew_fast, pb_slew_fast}, 8'hF5)
        `CHK(pc_oe_n_q, 8'h55)
        wr(`PMCL_OFF_DRV_C, 8'h00);
        @(posedge clk_sys);
        jtag_en <= 1'b1;
        {jtag_tdo_en, jtag_tdo} <= 2'h3;
        w(3);
        `CHK({pc_oe_n_q, pc_out_q[3]}, 9'h001)
        @(posedge clk_sys);
        jtag_tdo_en <= 1'b0;
        w(3);
        `CHK(pc_oe_n_q, 8'h08)
        @(posedge clk_sys);
        jtag_en <= 1'b0;
        $display("test drive and scan done");
        wr(`PMCL_OFF_MEM_MODE, 8'h80);
        rdc(`PMCL_OFF_MEM_MODE, 8'h80);
        w(1);
        `CHK(pa_oe_n_q, 8'hFF)
        for (k = 1; k < 4; k++) begin
            @(posedge clk_sys);
            {peripheral_select_b, peripheral_select_a} <= k[1:0];
            periph_write <= 1'b1;
            w(3);
            `CHK({pa_oe_n_q, pa_out_q}, {8'h00, host_wdata})
        end
        @(posedge clk_sys);
        periph_write <= 1'b0;
        w(3);
        `CHK(pa_oe_n_q, 8'hFF)
        @(posedge clk_sys);
        {peripheral_select_b, peripheral_select_a} <= 2'h0;
        wr(`PMCL_OFF_MEM_MODE, 8'h00);
        $display("test peripheral done");
        @(posedge clk_sys);
        {data_port_en, data_port_drive} <= 2'h3;
        {data_port_wdata, pa_in} <= 16'($urandom);
        w(6);
        `CHK({pa_oe_n_q, pa_out_q}, {8'h00, data_port_wdata})
        `CHK(data_port_rdata, pa_in)
        `CHK(periph_rdata, pa_in)
        @(posedge clk_sys);
        data_port_drive <= 1'b0;
        addr_strobe <= 1'b1;
        @(posedge clk_sys);
        addr_strobe <= 1'b0;
        w(2);
        `CHK({pa_oe_n_q, addr_in_a_q}, {8'hFF, pa_in})
        `CHK({addr_in_b_q, addr_in_c_q}, {pb_in, pc_in})
        `CHK({pin_sync_a, pin_sync_b, pin_sync_c, pin_sync_d},
             {pa_in, pb_in, pc_in, pd_in})
        $display("test data port done");
        end_sim;
    end
endmodule
